// ===== rtl/tmr2_ctrl.v
/*
   Second timer control, counter, capture/reload, baud clock selection
   and interrupt logic, with a simple register port.
   Assumes a single 250 MHz core clock; the event and trigger pins are
   asynchronous; the other timer's overflow pulse is on the core clock.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "tmr2_regs.vh"

module tmr2_ctrl
#(
   parameter CW = 16
)
(
   input wire CLK_SYS,
   input wire RSTN,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   input wire EVENT_IN,
   input wire TRIGGER_IN,
   input wire T1_OVF,
   output reg RX_BAUD_TICK,
   output reg TX_BAUD_TICK,
   output reg TIMER_IRQ,
   output reg IRQ
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   reg [2:0] mode_q;
   reg [1:0] stat_q;
   reg [1:0] stat_d;
   reg [1:0] mask_q;
   reg [CW-1:0] count_q;
   reg [CW-1:0] count_d;
   reg [CW-1:0] reload_q;
   reg [CW-1:0] reload_d;
   reg [3:0] pre_q;
   wire [1:0] pin_fall;
   wire ev_fall;
   wire trig_fall;
   wire tick;
   wire step;
   wire ovf;
   wire baud;
   wire trig_act;
   wire do_cap;
   wire do_trig_reload;
   wire ext_set;
   wire ovf_set;
   wire wr_ctrl;
   wire rd_stat;
   wire wr_mask;
   wire wr_mode;
   wire wr_count;
   wire wr_reload;
   wire cap_mode;
   wire src_pulse;
   wire [3:0] pre_last;

   reg [31:0] rdata_d;
   reg rx_tick_d;
   reg tx_tick_d;
   reg timer_irq_d;
   reg irq_d;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Pin edges act three core cycles after the pin moves; each level
   // on either pin must last at least one cycle to be seen.
   tmr2_sync #(.WIDTH(2)) u_sync
   (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .din({TRIGGER_IN, EVENT_IN}),
      .fall(pin_fall)
   );

   assign ev_fall = pin_fall[0];
   assign trig_fall = pin_fall[1];

   ////////////////////////////////////////////////////////////////////////
   // Internal tick prescaler

   // Six-clock mode halves the divide; the prescaler restarts from zero
   // whenever it reaches its last count, so a mode change takes effect
   // within one tick period.
   assign pre_last = mode_q[`TMR2_M_SIX] ? `TMR2_DIV6_LAST
                                          : `TMR2_DIV12_LAST;

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         pre_q <= 4'h0;
      else if (pre_q >= pre_last)
         pre_q <= 4'h0;
      else
         pre_q <= pre_q + 4'h1;
   end

   // The prescaler runs even while the timer is stopped, so the first
   // tick after a start may come early by up to one tick period.
   assign tick = (pre_q >= pre_last);

   ////////////////////////////////////////////////////////////////////////
   // Counting, overflow, capture and reload

   assign src_pulse = ctrl_q[`TMR2_B_SRC] ? ev_fall : tick;
   assign step = ctrl_q[`TMR2_B_RUN] & src_pulse;
   assign ovf = step & (count_q == `TMR2_COUNT_MAX);
   assign baud = ctrl_q[`TMR2_B_RXSEL] | ctrl_q[`TMR2_B_TXSEL];
   // In baud mode the trigger neither captures nor reloads.
   assign trig_act = trig_fall & ctrl_q[`TMR2_B_TRIGEN] & ~baud;
   assign do_cap = trig_act & ctrl_q[`TMR2_B_CAP];
   assign do_trig_reload = trig_act & ~ctrl_q[`TMR2_B_CAP];
   assign ext_set = do_cap | do_trig_reload;
   assign ovf_set = ovf & ~baud;

   assign wr_ctrl = WR & (ADDR == `TMR2_ADDR_CTRL);
   assign rd_stat = RD & (ADDR == `TMR2_ADDR_STAT);
   assign wr_mask = WR & (ADDR == `TMR2_ADDR_MASK);
   assign wr_mode = WR & (ADDR == `TMR2_ADDR_MODE);
   assign wr_count = WR & (ADDR == `TMR2_ADDR_COUNT);
   assign wr_reload = WR & (ADDR == `TMR2_ADDR_RELOAD);

   // Baud mode forces reload on overflow whatever the capture select says.
   assign cap_mode = ctrl_q[`TMR2_B_CAP] & ~baud;

   always @*
   begin
      count_d = count_q;
      // A preset from software wins over a coincident tick or overflow,
      // but a trigger reload in the same cycle overrides it.
      if (wr_count)
         count_d = WDATA[CW-1:0];
      else if (ovf)
      begin
         // Capture mode lets the count roll over to zero.
         if (cap_mode)
            count_d = {CW{1'b0}};
         else
            count_d = reload_q;
      end
      else if (step)
         count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
      if (do_trig_reload)
         count_d = reload_q;
   end

   always @*
   begin
      reload_d = reload_q;
      if (wr_reload)
         reload_d = WDATA[CW-1:0];
      // A capture wins over a software write in the same cycle.
      if (do_cap)
         reload_d = count_q;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         count_q <= `TMR2_WORD_RST;
      else
         count_q <= count_d;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         reload_q <= `TMR2_WORD_RST;
      else
         reload_q <= reload_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register

   // Software may write both flags; a hardware set in the same cycle
   // wins, so no event is lost to a clearing write.
   always @*
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
         ctrl_d = WDATA[7:0];
      if (ovf_set)
         ctrl_d[`TMR2_B_OVF] = 1'b1;
      if (ext_set)
         ctrl_d[`TMR2_B_EXT] = 1'b1;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         ctrl_q <= `TMR2_CTRL_RST;
      else
         ctrl_q <= ctrl_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode and mask registers

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         mode_q <= `TMR2_MODE_RST;
      else if (wr_mode)
         mode_q <= WDATA[2:0];
   end

   // Mask and status share one layout, so bit n of each goes together.
   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         mask_q <= `TMR2_IRQ_RST;
      else if (wr_mask)
         mask_q <= WDATA[1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky event status, cleared by reading it

   always @*
   begin
      stat_d = stat_q;
      // An event in the cycle of the clearing read still lands, so it
      // is reported by the next read instead of being lost.
      if (rd_stat)
         stat_d = 2'h0;
      if (ovf)
         stat_d[`TMR2_S_OVF] = 1'b1;
      if (ext_set)
         stat_d[`TMR2_S_EXT] = 1'b1;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         stat_q <= `TMR2_IRQ_RST;
      else
         stat_q <= stat_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read port

   always @*
   begin
      // Idle cycles read as zero, so several slaves may share an OR-ed
      // read bus without any select on the return path.
      rdata_d = 32'h0000_0000;
      if (RD)
      begin
         case (ADDR)
            `TMR2_ADDR_CTRL:
               rdata_d[7:0] = ctrl_q;
            `TMR2_ADDR_STAT:
               rdata_d[1:0] = stat_q;
            `TMR2_ADDR_MASK:
               rdata_d[1:0] = mask_q;
            `TMR2_ADDR_MODE:
               rdata_d[2:0] = mode_q;
            `TMR2_ADDR_COUNT:
               rdata_d[CW-1:0] = count_q;
            `TMR2_ADDR_RELOAD:
               rdata_d[CW-1:0] = reload_q;
            default:
               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         RDATA <= 32'h0000_0000;
      else
         RDATA <= rdata_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Baud clocks and interrupt outputs

   // The overflow pulse still reaches the serial port in baud mode even
   // though the overflow flag stays clear there.
   always @*
   begin
      rx_tick_d = T1_OVF;
      if (ctrl_q[`TMR2_B_RXSEL])
         rx_tick_d = ovf;
      tx_tick_d = T1_OVF;
      if (ctrl_q[`TMR2_B_TXSEL])
         tx_tick_d = ovf;
      // Levels follow next-state flags so each output flop lines up with
      // the flag or status bit that drives it.
      timer_irq_d = ctrl_d[`TMR2_B_OVF];
      if (ctrl_d[`TMR2_B_EXT] && !mode_q[`TMR2_M_UPDN])
         timer_irq_d = 1'b1;
      if (!mode_q[`TMR2_M_INTEN])
         timer_irq_d = 1'b0;
      irq_d = |(stat_d & mask_q);
   end

   // Every output comes straight from its own flop, low during reset.
   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         RX_BAUD_TICK <= 1'b0;
      else
         RX_BAUD_TICK <= rx_tick_d;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         TX_BAUD_TICK <= 1'b0;
      else
         TX_BAUD_TICK <= tx_tick_d;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         TIMER_IRQ <= 1'b0;
      else
         TIMER_IRQ <= timer_irq_d;
   end

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         IRQ <= 1'b0;
      else
         IRQ <= irq_d;
   end

endmodule // tmr2_ctrl

`default_nettype wire

// ===== rtl/tmr2_regs.vh
/*
   Register offsets, field positions, reset values and divider counts
   for the second timer control block.
   Assumes byte addresses on an 8-bit address port, 32-bit data.
*/
`ifndef TMR2_REGS_VH
`define TMR2_REGS_VH

`define TMR2_ADDR_CTRL 8'hC8
`define TMR2_ADDR_STAT 8'hCC
`define TMR2_ADDR_MASK 8'hD0
`define TMR2_ADDR_MODE 8'hD4
`define TMR2_ADDR_COUNT 8'hD8
`define TMR2_ADDR_RELOAD 8'hDC

`define TMR2_CTRL_RST 8'h00
`define TMR2_MODE_RST 3'h0
`define TMR2_IRQ_RST 2'h0
`define TMR2_WORD_RST 16'h0000

`define TMR2_B_OVF 7
`define TMR2_B_EXT 6
`define TMR2_B_RXSEL 5
`define TMR2_B_TXSEL 4
`define TMR2_B_TRIGEN 3
`define TMR2_B_RUN 2
`define TMR2_B_SRC 1
`define TMR2_B_CAP 0

`define TMR2_M_UPDN 0
`define TMR2_M_SIX 1
`define TMR2_M_INTEN 2

`define TMR2_S_OVF 0
`define TMR2_S_EXT 1

`define TMR2_DIV6_LAST 4'h5
`define TMR2_DIV12_LAST 4'hB
`define TMR2_COUNT_MAX 16'hFFFF

`endif

// ===== rtl/tmr2_sync.v
/*
   Two-flop synchroniser with falling edge detect, one lane per bit.
   Assumes inputs are asynchronous pins and one core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tmr2_sync
#(
   parameter WIDTH = 2
)
(
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] fall
);

   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_lane
         reg meta_q;
         reg sync_q;
         reg last_q;
         // The first stage feeds only the second one.
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
               last_q <= 1'b1;
            end
            else
            begin
               meta_q <= din[i];
               sync_q <= meta_q;
               last_q <= sync_q;
            end
         end
         assign fall[i] = last_q & ~sync_q;
      end
   endgenerate

endmodule // tmr2_sync

`default_nettype wire

// ===== verif/tb_tmr2_ctrl.sv
/* Self-checking bench for tmr2_ctrl.
   Assumes the far-side model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_tmr2_ctrl;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ev = 1'b1;
   logic trg = 1'b1;
   logic t1_en = 1'b0;
   logic [31:0] rng = 32'hC17FFD35;
   wire t1, rxt, txt, tirq, irq;
   wire [31:0] rdata;
   int failures = 0, compares = 0, cyc = 0, rx_n = 0, tx_n = 0, t1_n = 0;
   // Model: cycle numbers of other-timer pulses still owed as baud ticks.
   int t1_rx_q[$], t1_tx_q[$];
   tmr2_ctrl DUT (.CLK_SYS(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
      .WR(wr_s), .RD(rd_s), .RDATA(rdata), .EVENT_IN(ev), .TRIGGER_IN(trg),
      .T1_OVF(t1), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt),
      .TIMER_IRQ(tirq), .IRQ(irq));
   tmr2_far #(.PER(9)) u_far (.clk(clk), .rst_n(rstn), .en(t1_en),
      .t1_ovf(t1));
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      rx_n += (rxt === 1'b1);
      tx_n += (txt === 1'b1);
      t1_n += (t1 === 1'b1);
      if (t1 === 1'b1)
      begin
         t1_rx_q.push_back(cyc);
         t1_tx_q.push_back(cyc);
      end
      if (rxt === 1'b1 && t1_rx_q.size() > 0)
         chk("rx t1 lag", 1, cyc - t1_rx_q.pop_front());
      if (txt === 1'b1 && t1_tx_q.size() > 0)
         chk("tx t1 lag", 1, cyc - t1_tx_q.pop_front());
      if (cyc == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input int e);
      logic [31:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask
   // Pins hold each level for four cycles to clear the synchroniser.
   task automatic fall(input logic t);
      @(posedge clk);
      if (t)
         trg <= 1'b0;
      else
         ev <= 1'b0;
      repeat (4) @(posedge clk);
      ev <= 1'b1;
      trg <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] a, b, c, v;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rchk("ctrl reset", 8'hC8, 0);
      rchk("unmapped", 8'h00, 0);
      for (int m = 0; m < 3; m++)
      begin
         wr(8'hD4, {30'h0, m == 1, 1'b0});
         wr(8'hC8, m == 2 ? 32'h0 : 32'h4);
         rd(8'hD8, a);
         repeat (58) @(posedge clk);
         rd(8'hD8, b);
         chk("ticks", m == 2 ? 0 : 60 / (m == 1 ? 6 : 12), b - a);
      end
      wr(8'hC8, 32'h6);
      rng = xs(rng);
      rd(8'hD8, a);
      repeat (rng[2:0] + 1) fall(1'b0);
      rd(8'hD8, b);
      chk("events", rng[2:0] + 1, b - a);
      v = {16'h0, rng[31:16]};
      wr(8'hDC, v);
      wr(8'hD8, 32'hFFFF);
      wr(8'hD0, 32'h3);
      wr(8'hD4, 32'h4);
      fall(1'b0);
      rchk("ovf reload", 8'hD8, v);
      rchk("ctrl", 8'hC8, 32'h86);
      chk("irq", 32'h1, {31'h0, irq});
      chk("timer irq", 32'h1, {31'h0, tirq});
      rchk("status", 8'hCC, 1);
      repeat (2) @(posedge clk);
      #1 chk("irq clear", 32'h0, {31'h0, irq});
      wr(8'hC8, 32'hF);
      v = {16'h0, rng[15:0]};
      wr(8'hD8, v);
      fall(1'b1);
      rchk("capture", 8'hDC, v);
      rchk("ctrl", 8'hC8, 32'h4F);
      chk("ext irq", 32'h1, {31'h0, tirq});
      wr(8'hD4, 32'h5);
      repeat (2) @(posedge clk);
      #1 chk("updn irq", 32'h0, {31'h0, tirq});
      wr(8'hC8, 32'hE);
      wr(8'hDC, v ^ 32'hA5A5);
      fall(1'b1);
      rchk("trig reload", 8'hD8, v ^ 32'hA5A5);
      rchk("ctrl", 8'hC8, 32'h4E);
      // Receive baud select first, then transmit baud select alone.
      for (int s = 0; s < 2; s++)
      begin
         wr(8'hC8, s ? 32'h1F : 32'h2F);
         wr(8'hD8, 32'hFFFF);
         fall(1'b1);
         rchk("baud trig", 8'hD8, 32'hFFFF);
         a = rx_n;
         b = tx_n;
         fall(1'b0);
         rchk("baud reload", 8'hD8, v ^ 32'hA5A5);
         rchk("ctrl", 8'hC8, s ? 32'h1F : 32'h2F);
         chk("rx ticks", a + (s ? 0 : 1), rx_n);
         chk("tx ticks", b + s, tx_n);
      end
      wr(8'hC8, 32'h0);
      #1 a = rx_n;
      b = tx_n;
      c = t1_n;
      @(posedge clk) t1_en <= 1'b1;
      repeat (90) @(posedge clk);
      t1_en <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("rx from t1", t1_n - c, rx_n - a);
      chk("tx from t1", t1_n - c, tx_n - b);
      tally_and_finish();
   end
endmodule // tb_tmr2_ctrl
`default_nettype wire

// ===== verif/tmr2_ctrl_properties.sv
/* Port checker for the second timer control block.
   Assumes it is bound to tmr2_ctrl and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module tmr2_chk (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic T1_OVF,
   input wire logic RX_BAUD_TICK,
   input wire logic TX_BAUD_TICK,
   input wire logic TIMER_IRQ,
   input wire logic IRQ
);
   // Shadows of what software wrote, plus the flags seen by control reads; hardware only ever sets flags.
   logic [7:0] ctl_q;
   logic [1:0] seen_q;
   logic [2:0] mode_q;
   logic [1:0] mask_q;
   logic rdc_q;
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctl_q <= 8'h00;
         seen_q <= 2'h0;
         mode_q <= 3'h0;
         mask_q <= 2'h0;
         rdc_q <= 1'b0;
      end
      else
      begin
         rdc_q <= RD && ADDR == 8'hC8;
         if (WR && ADDR == 8'hC8)
         begin
            ctl_q <= WDATA[7:0];
            seen_q <= 2'h0;
         end
         else if (rdc_q)
            seen_q <= seen_q | RDATA[7:6];
         if (WR && ADDR == 8'hD4)
            mode_q <= WDATA[2:0];
         if (WR && ADDR == 8'hD0)
            mask_q <= WDATA[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   a_rx_from_t1: assert property (!ctl_q[5] && T1_OVF |=> RX_BAUD_TICK)
      else $error("rx tick missing");
   a_tx_from_t1: assert property (!ctl_q[4] && T1_OVF |=> TX_BAUD_TICK)
      else $error("tx tick missing");
   a_ticks_agree: assert property (ctl_q[5] == ctl_q[4]
      |=> RX_BAUD_TICK == TX_BAUD_TICK) else $error("ticks differ");
   a_ovf_quiet: assert property (RD && ADDR == 8'hC8 && !ctl_q[7]
      && |ctl_q[5:4] |=> !RDATA[7]) else $error("flag set in baud");
   a_flags_sticky: assert property (RD && ADDR == 8'hC8
      |=> (RDATA[7:6] & seen_q) == seen_q) else $error("flag lost");
   a_int_gate: assert property (!mode_q[2] |=> !TIMER_IRQ)
      else $error("timer irq while disabled");
   a_irq_masked: assert property (mask_q == 2'h0 |=> !IRQ)
      else $error("irq while masked");
   a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data outside read");
endmodule // tmr2_chk
bind tmr2_ctrl tmr2_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .T1_OVF(T1_OVF),
   .RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK),
   .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));
`default_nettype wire

// ===== verif/tmr2_far.sv
/* Far-side model: overflow pulses of the other timer.
   Assumes the core clock and an active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module tmr2_far #(
   parameter PER = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   output logic t1_ovf
);
   logic [7:0] cnt_q;
   // The pulse lasts one core cycle, as the real timer's overflow does.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 8'h00;
         t1_ovf <= 1'b0;
      end
      else
      begin
         cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
         t1_ovf <= en && cnt_q == 8'h00;
      end
   end
endmodule // tmr2_far
`default_nettype wire
